// File: src/flash_link_pkg.sv
// Shared constants, types and helpers for the flash link host and device.
// What this block does
// - Insert programmed dummy clocks after fast read.
// - Dummy codes 0000 and 1111 mean default.
// - Host programs enough dummy cycles for clock.
// - Nonvolatile bits 2,3 select dual/quad protocol.
// - Volatile bit 3 at 0 enables execute-in-place.
// - Bits 1:0 select 16/32/64 wrap or sequential.
// - Wrap starts at address, stays in block.
// - Sequential code reads incrementing addresses.
// - New values apply when write command completes.
// - Register reached only by its own commands.
// - Host picks dummy count per read, rate.
// - Double-rate clock limits follow dummy count; the host sends only single-rate frames.
package flash_link_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Link commands.
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_READ_VCR  = 8'h85;
    localparam logic [7:0] CMD_WRITE_VCR = 8'h81;

    // Volatile read configuration layout and reset value.
    localparam int         VCR_DUMMY_MSB = 7;
    localparam int         VCR_DUMMY_LSB = 4;
    localparam int         VCR_XIP_BIT   = 3;
    localparam logic [7:0] VCR_RESET     = 8'hFB;
    localparam logic [7:0] VCR_WMASK     = 8'hFB;
    localparam logic [3:0] DUMMY_DEFAULT = 4'hA;

    // Wrap codes.
    localparam logic [1:0] WRAP_16  = 2'h0;
    localparam logic [1:0] WRAP_32  = 2'h1;
    localparam logic [1:0] WRAP_64  = 2'h2;
    localparam logic [1:0] WRAP_SEQ = 2'h3;

    // I/O protocol chosen at power-on.
    typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;

    ////////////////////////////////////////////////////////////////////////////
    // Host register map and fields.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DUMMY  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [1:0] OP_READ_VCR  = 2'h0;
    localparam logic [1:0] OP_WRITE_VCR = 2'h1;
    localparam logic [1:0] OP_FAST_READ = 2'h2;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // Last divider count of a serial clock half period, and link reset length in rises.
    localparam logic [1:0] SCLK_HALF      = 2'h3;
    localparam logic [2:0] DEV_RST_RISES  = 3'h4;

    // Effective dummy clocks for a code; 0 and F both mean the default.
    function automatic logic [3:0] dummy_cycles(input logic [3:0] code);
        if (code == 4'h0 || code == 4'hF) begin
            return DUMMY_DEFAULT;
        end
        return code;
    endfunction : dummy_cycles

endpackage : flash_link_pkg

// File: src/flash_link_if.sv
// Serial link between the flash controller and the flash register device.
`timescale 1ns/1ps
interface flash_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic rst_n;

    // Controller end drives clock, select, data out and link reset.
    modport host (output sclk, output cs_n, output mosi, output rst_n, input miso);

    // Device end runs on the link clock.
    modport dev (input sclk, input cs_n, input mosi, input rst_n, output miso);
endinterface : flash_link_if

// File: src/flash_vcr_device.sv
// Flash device end: volatile read configuration register and fast read path.
`timescale 1ns/1ps
module flash_vcr_device #(
    parameter bit XIP_FORCED = 1'b0
) (
    // Serial link.
    flash_link_if.dev               link,
    // Nonvolatile protocol bits 3:2, sampled after link reset.
    input  wire logic [1:0]         nv_proto_bits,
    // Current configuration seen by the array logic.
    output flash_link_pkg::proto_t  proto_mode_q,
    output logic                    execute_in_place_q,
    output logic [1:0]              wrap_mode_q,
    output logic [3:0]              dummy_cycles_q
);

    typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_RDREG, ST_WDATA, ST_IDLE} dev_state_t;

    dev_state_t  state_q;
    logic [4:0]  cnt_q;
    logic [7:0]  sh_q;
    logic [7:0]  tx_q;
    logic [23:0] addr_q;
    logic [7:0]  vcr_q;
    logic [7:0]  wr_val_q;
    logic        wr_pend_q;
    logic        miso_q;
    logic        strap_done_q;
    logic [7:0]  cmd_in;
    logic [23:0] wrap_mask;
    logic [23:0] next_addr;

    assign link.miso = miso_q;
    assign cmd_in    = {sh_q[6:0], link.mosi};

    ////////////////////////////////////////////////////////////////////////////
    // Next read address: wraps inside the aligned block, or increments freely.
    always_comb begin
        case (vcr_q[1:0])
            flash_link_pkg::WRAP_16: wrap_mask = 24'h00000F;
            flash_link_pkg::WRAP_32: wrap_mask = 24'h00001F;
            flash_link_pkg::WRAP_64: wrap_mask = 24'h00003F;
            default: wrap_mask = 24'hFFFFFF;
        endcase
        next_addr = (addr_q & ~wrap_mask) | ((addr_q + 24'h000001) & wrap_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame decoder, clocked by the link clock; a high select ends any frame.
    always_ff @(posedge link.sclk) begin
        if (!link.rst_n) begin
            state_q   <= ST_CMD;
            cnt_q     <= 5'h00;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            addr_q    <= 24'h000000;
            miso_q    <= 1'b0;
            wr_val_q  <= 8'h00;
            wr_pend_q <= 1'b0;
        end else if (link.cs_n) begin
            state_q   <= ST_CMD;
            cnt_q     <= 5'h00;
            miso_q    <= 1'b0;
            wr_pend_q <= 1'b0;
        end else begin
            case (state_q)
                ST_CMD: begin
                    sh_q  <= cmd_in;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h07) begin
                        cnt_q <= 5'h00;
                        // Only the dedicated commands reach the register.
                        case (cmd_in)
                            flash_link_pkg::CMD_FAST_READ: state_q <= ST_ADDR;
                            flash_link_pkg::CMD_READ_VCR: begin
                                state_q <= ST_RDREG;
                                miso_q  <= vcr_q[7];
                                tx_q    <= {vcr_q[6:0], 1'b0};
                            end
                            flash_link_pkg::CMD_WRITE_VCR: state_q <= ST_WDATA;
                            default:       state_q <= ST_IDLE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[22:0], link.mosi};
                    cnt_q  <= cnt_q + 5'h01;
                    if (cnt_q == 5'h17) begin
                        cnt_q   <= 5'h00;
                        state_q <= ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    cnt_q <= cnt_q + 5'h01;
                    // The last dummy rise puts the first data bit out.
                    if (cnt_q + 5'h01 == {1'b0, flash_link_pkg::dummy_cycles(vcr_q[7:4])}) begin
                        cnt_q   <= 5'h00;
                        state_q <= ST_DATA;
                        miso_q  <= addr_q[7];
                        tx_q    <= {addr_q[6:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h07) begin
                        cnt_q  <= 5'h00;
                        addr_q <= next_addr;
                        miso_q <= next_addr[7];
                        tx_q   <= {next_addr[6:0], 1'b0};
                    end else begin
                        miso_q <= tx_q[7];
                        tx_q   <= {tx_q[6:0], 1'b0};
                    end
                end
                ST_RDREG: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h07) begin
                        cnt_q  <= 5'h00;
                        miso_q <= vcr_q[7];
                        tx_q   <= {vcr_q[6:0], 1'b0};
                    end else begin
                        miso_q <= tx_q[7];
                        tx_q   <= {tx_q[6:0], 1'b0};
                    end
                end
                ST_WDATA: begin
                    sh_q  <= cmd_in;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h07) begin
                        wr_val_q  <= cmd_in;
                        wr_pend_q <= 1'b1;
                        state_q   <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The register takes a written value at the first rise after select ends.
    always_ff @(posedge link.sclk) begin
        if (!link.rst_n) begin
            vcr_q <= flash_link_pkg::VCR_RESET;
        end else if (link.cs_n && wr_pend_q) begin
            vcr_q <= wr_val_q & flash_link_pkg::VCR_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protocol straps are caught once, at the first rise after link reset.
    always_ff @(posedge link.sclk) begin
        if (!link.rst_n) begin
            strap_done_q <= 1'b0;
            proto_mode_q <= flash_link_pkg::PROTO_EXT;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            case (nv_proto_bits)
                2'h0, 2'h1: proto_mode_q <= flash_link_pkg::PROTO_QUAD;
                2'h2:       proto_mode_q <= flash_link_pkg::PROTO_DUAL;
                default:    proto_mode_q <= flash_link_pkg::PROTO_EXT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration outputs for the array logic.
    always_ff @(posedge link.sclk) begin
        if (!link.rst_n) begin
            execute_in_place_q <= 1'b0;
            wrap_mode_q        <= flash_link_pkg::WRAP_SEQ;
            dummy_cycles_q     <= flash_link_pkg::DUMMY_DEFAULT;
        end else begin
            execute_in_place_q <= XIP_FORCED | ~vcr_q[flash_link_pkg::VCR_XIP_BIT];
            wrap_mode_q        <= vcr_q[1:0];
            dummy_cycles_q     <= flash_link_pkg::dummy_cycles(
                vcr_q[flash_link_pkg::VCR_DUMMY_MSB:flash_link_pkg::VCR_DUMMY_LSB]);
        end
    end

endmodule : flash_vcr_device

// File: src/flash_link_host.sv
// Flash controller end: AXI4-Lite register slave driving the serial link.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module flash_link_host (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response.
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read.
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Serial link.
    flash_link_if.host       link
);

    typedef enum {L_IDLE, L_ARM, L_RUN} link_state_t;

    link_state_t lstate_q;
    logic [7:0]  waddr_q;
    logic [31:0] wdat_q;
    logic [3:0]  wstb_q;
    logic        aw_full_q;
    logic        w_full_q;
    logic [17:0] ctrl_q;
    logic [23:0] addr_q;
    logic [3:0]  dummy_code_q;
    logic        start_q;
    logic [31:0] rx_q;
    logic [31:0] tx_q;
    logic [6:0]  rc_q;
    logic [6:0]  rx_from_q;
    logic [6:0]  total_q;
    logic [1:0]  div_q;
    logic        sclk_q;
    logic        cs_n_q;
    logic        mosi_q;
    logic        dev_rst_n_q;
    logic [2:0]  rst_cnt_q;
    logic [2:0]  miso_s_q;
    logic        miso_f_q;
    logic        wr_fire;
    logic        busy;
    logic        rise_next;
    logic        fall_next;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic        rd_hit;

    assign link.sclk  = sclk_q;
    assign link.cs_n  = cs_n_q;
    assign link.mosi  = mosi_q;
    assign link.rst_n = dev_rst_n_q;

    assign wr_fire   = aw_full_q && w_full_q && !bvalid;
    assign busy      = (lstate_q != L_IDLE) || start_q || !dev_rst_n_q;
    assign rise_next = (div_q == flash_link_pkg::SCLK_HALF) && !sclk_q;
    assign fall_next = (div_q == flash_link_pkg::SCLK_HALF) && sclk_q;
    assign wmask     = {{8{wstb_q[3]}}, {8{wstb_q[2]}}, {8{wstb_q[1]}}, {8{wstb_q[0]}}};

    ////////////////////////////////////////////////////////////////////////////
    // Write channels are taken in either order; the response follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdat_q    <= 32'h00000000;
            wstb_q    <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= flash_link_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                waddr_q   <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                wdat_q   <= wdata;
                wstb_q   <= wstrb;
                wready   <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (waddr_q < flash_link_pkg::REG_STATUS && waddr_q[1:0] == 2'h0) ?
                             flash_link_pkg::RESP_OKAY : flash_link_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; a control write with lane 0 set while not busy starts a frame.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q       <= 18'h00000;
            addr_q       <= 24'h000000;
            dummy_code_q <= 4'h0;
            start_q      <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_fire && waddr_q == flash_link_pkg::REG_CTRL && !busy) begin
                ctrl_q  <= (ctrl_q & ~wmask[17:0]) | (wdat_q[17:0] & wmask[17:0]);
                start_q <= wstb_q[0];
            end
            if (wr_fire && waddr_q == flash_link_pkg::REG_ADDR) begin
                addr_q <= (addr_q & ~wmask[23:0]) | (wdat_q[23:0] & wmask[23:0]);
            end
            // Software must match this to the device setting and clock rate.
            if (wr_fire && waddr_q == flash_link_pkg::REG_DUMMY && wstb_q[0]) begin
                dummy_code_q <= wdat_q[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one aligned word per register, unmapped gives an error.
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            flash_link_pkg::REG_CTRL:   rd_val = {14'h0000, ctrl_q};
            flash_link_pkg::REG_ADDR:   rd_val = {8'h00, addr_q};
            flash_link_pkg::REG_DUMMY:  rd_val = {28'h0000000, dummy_code_q};
            flash_link_pkg::REG_STATUS: rd_val = {30'h00000000, dev_rst_n_q, busy};
            flash_link_pkg::REG_RDATA:  rd_val = rx_q;
            default: begin
                rd_val = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= flash_link_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_val;
            rresp   <= rd_hit ? flash_link_pkg::RESP_OKAY : flash_link_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free-running serial clock divider; only single-rate frames are sent.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q  <= 2'h0;
            sclk_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (rise_next || fall_next) begin
                div_q  <= 2'h0;
                sclk_q <= ~sclk_q;
            end
        end
    end

    // Device link reset is held for a few serial clock rises.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt_q   <= 3'h0;
            dev_rst_n_q <= 1'b0;
        end else if (rise_next && rst_cnt_q != flash_link_pkg::DEV_RST_RISES) begin
            rst_cnt_q <= rst_cnt_q + 3'h1;
        end else if (rst_cnt_q == flash_link_pkg::DEV_RST_RISES && fall_next) begin
            dev_rst_n_q <= 1'b1;
        end
    end

    // Returned data passes three synchronizer flops and a filter flop; a change counts once the last two synchronizer flops agree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            miso_s_q <= 3'h0;
            miso_f_q <= 1'b0;
        end else begin
            miso_s_q <= {miso_s_q[1:0], link.miso};
            if (miso_s_q[1] == miso_s_q[2]) begin
                miso_f_q <= miso_s_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame engine: bits leave on the falling half, replies are taken before
    // each rise once the command (a register write takes none), and for a fast read the address and dummy clocks, have passed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lstate_q  <= L_IDLE;
            cs_n_q    <= 1'b1;
            mosi_q    <= 1'b0;
            tx_q      <= 32'h00000000;
            rx_q      <= 32'h00000000;
            rc_q      <= 7'h00;
            rx_from_q <= 7'h00;
            total_q   <= 7'h00;
        end else begin
            case (lstate_q)
                L_IDLE: begin
                    if (start_q) begin
                        lstate_q <= L_ARM;
                        rc_q     <= 7'h00;
                        case (ctrl_q[1:0])
                            flash_link_pkg::OP_WRITE_VCR: begin
                                tx_q <= {flash_link_pkg::CMD_WRITE_VCR, ctrl_q[15:8], 16'h0000};
                                rx_from_q <= 7'h10;
                                total_q   <= 7'h10;
                            end
                            flash_link_pkg::OP_FAST_READ: begin
                                tx_q      <= {flash_link_pkg::CMD_FAST_READ, addr_q};
                                rx_from_q <= 7'h20 +
                                             {3'h0, flash_link_pkg::dummy_cycles(dummy_code_q)};
                                total_q   <= 7'h28 + {2'h0, ctrl_q[17:16], 3'h0} +
                                             {3'h0, flash_link_pkg::dummy_cycles(dummy_code_q)};
                            end
                            default: begin
                                tx_q      <= {flash_link_pkg::CMD_READ_VCR, 24'h000000};
                                rx_from_q <= 7'h08;
                                total_q   <= 7'h10;
                            end
                        endcase
                    end
                end
                L_ARM: begin
                    if (fall_next) begin
                        cs_n_q   <= 1'b0;
                        mosi_q   <= tx_q[31];
                        tx_q     <= {tx_q[30:0], 1'b0};
                        rx_q     <= 32'h00000000;
                        lstate_q <= L_RUN;
                    end
                end
                L_RUN: begin
                    if (rise_next) begin
                        rc_q <= rc_q + 7'h01;
                        if (rc_q >= rx_from_q && rc_q < total_q) begin
                            rx_q <= {rx_q[30:0], miso_f_q};
                        end
                    end
                    if (fall_next) begin
                        if (rc_q == total_q) begin
                            cs_n_q   <= 1'b1;
                            mosi_q   <= 1'b0;
                            lstate_q <= L_IDLE;
                        end else begin
                            mosi_q <= tx_q[31];
                            tx_q   <= {tx_q[30:0], 1'b0};
                        end
                    end
                end
                default: lstate_q <= L_IDLE;
            endcase
        end
    end

endmodule : flash_link_host

// File: verif/flash_link_sva.sv
// Checker of the serial link between flash controller and register device.
`timescale 1ns/1ps
module flash_link_sva (
    // Link.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic rst_n
);
    logic [6:0]  n_q, d, j;
    logic [31:0] sh_q;
    logic [7:0]  cmd_q, adr_q, vcr_q, cmd, nxt, m;
    default clocking @(posedge sclk); endclocking
    default disable iff (!rst_n);
    // Frame rise count, command, address byte and expected register.
    always_ff @(posedge sclk) begin
        n_q  <= (!rst_n || cs_n) ? 7'h00 : n_q + 7'h01;
        sh_q <= {sh_q[30:0], mosi};
        if (n_q == 7'h08) cmd_q <= sh_q[7:0];
        if (n_q == 7'h20) adr_q <= sh_q[7:0];
        if (!rst_n) vcr_q <= 8'hFB;
        else if (cs_n && cmd_q == 8'h81 && n_q == 7'h10) vcr_q <= sh_q[7:0] & 8'hFB;
    end
    // Dummy count, data bit index, second byte address.
    assign cmd = (n_q == 7'h08) ? sh_q[7:0] : cmd_q;
    assign d   = (vcr_q[7:4] == 4'h0 || vcr_q[7:4] == 4'hF) ? 7'h0A : {3'h0, vcr_q[7:4]};
    assign j   = n_q - 7'h20 - d;
    assign m   = (vcr_q[1:0] == 2'h3) ? 8'hFF : ((8'h0F << vcr_q[1:0]) | 8'h0F);
    assign nxt = (adr_q & ~m) | ((adr_q + 8'h01) & m);
    chk_vcr_bits: assert property (
        !cs_n && cmd == 8'h85 && n_q >= 7'h08 && n_q <= 7'h0F |-> miso == vcr_q[4'hF - n_q[3:0]])
        else $error("register bit wrong");
    chk_resv_zero: assert property (!cs_n && cmd == 8'h85 && n_q == 7'h0D |-> !miso)
        else $error("reserved bit set");
    chk_xip_bit: assert property (!cs_n && cmd == 8'h85 && n_q == 7'h0C |-> miso == vcr_q[3])
        else $error("xip bit wrong");
    chk_vcr_first: assert property (!cs_n && cmd == 8'h85 && n_q == 7'h08 |-> miso == vcr_q[7])
        else $error("first bit wrong");
    chk_fast_first: assert property (
        !cs_n && cmd_q == 8'h0B && j < 7'h08 |-> miso == adr_q[3'h7 - j[2:0]])
        else $error("first byte wrong");
    chk_dummy_dflt: assert property (
        !cs_n && cmd_q == 8'h0B && d == 7'h0A && j == 7'h00 |-> miso == adr_q[7])
        else $error("default dummy wrong");
    chk_wrap_next: assert property (
        !cs_n && cmd_q == 8'h0B && vcr_q[1:0] != 2'h3 && j[6:3] == 4'h1 |-> miso == nxt[3'h7 - j[2:0]])
        else $error("wrapped byte wrong");
    chk_seq_next: assert property (
        !cs_n && cmd_q == 8'h0B && vcr_q[1:0] == 2'h3 && j[6:3] == 4'h1 |-> miso == nxt[3'h7 - j[2:0]])
        else $error("sequential byte wrong");
endmodule : flash_link_sva

// File: verif/serial_flash_volatile_read_config_test.sv
// Testbench joining controller and device over the link.
`timescale 1ns/1ps
module serial_flash_volatile_read_config_test;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, execute_in_place;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, v, x, m;
    logic [31:0] wdata = 32'h0, rdata, rd, e;
    logic [3:0]  wstrb = 4'hF, dmy, c;
    logic [1:0]  nv = 2'h0, bresp, rresp, rr, wrap, n, proto;
    logic [23:0] a;
    int          err_count = 0, check_count = 0;
    flash_link_if lnk ();
    flash_link_host i_flash_link_host (.*, .link(lnk));
    flash_vcr_device i_flash_vcr_device (.link(lnk), .nv_proto_bits(nv), .proto_mode_q(proto),
        .execute_in_place_q(execute_in_place), .wrap_mode_q(wrap), .dummy_cycles_q(dmy));
    flash_link_sva i_sva (.sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
        .rst_n(lnk.rst_n));
    // System clock.
    always #20 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    // Compares one result and counts it.
    task automatic cmp(input logic [33:0] g, input logic [33:0] ex);
        check_count++;
        if (g !== ex) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, g, ex);
        end
    endtask : cmp
    task automatic finish_test;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= ad;
        wdata   <= dt;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp(bresp, er);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        dt = rdata;
        r  = rresp;
    endtask : axi_rd
    // Runs one link operation and fetches the received bits.
    task automatic run_op(input logic [31:0] ctrl);
        axi_wr(flash_link_pkg::REG_CTRL, ctrl, 2'h0);
        do axi_rd(flash_link_pkg::REG_STATUS, rd, rr); while (rd[0] !== 1'b1);
        do axi_rd(flash_link_pkg::REG_STATUS, rd, rr); while (rd[0] !== 1'b0);
        axi_rd(flash_link_pkg::REG_RDATA, rd, rr);
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake.
    initial begin
        #2_400_000;
        err_count++;
        finish_test();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h66B1));
        for (int p = 0; p < 4; p++) begin
            nv      <= 2'(p);
            aresetn <= 1'b0;
            repeat (4) @(posedge aclk);
            aresetn <= 1'b1;
            do axi_rd(flash_link_pkg::REG_STATUS, rd, rr); while (rd[1] !== 1'b1);
            repeat (16) @(posedge aclk); // Straps settle on the link clock.
            cmp(proto, (p == 3) ? 34'h0 : (p == 2) ? 34'h1 : 34'h2);
            cmp({dmy, wrap, execute_in_place}, {4'hA, 2'h3, 1'b0});
            run_op(32'h0);
            cmp(rd, 32'hFB);
        end
        for (int i = 0; i < 8; i++) begin
            c = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom_range(14, 1));
            v = {c, 2'($urandom), 2'(i)};
            a = 24'($urandom);
            n = 2'($urandom);
            m = (v[1:0] == 2'h3) ? 8'hFF : ((8'h0F << v[1:0]) | 8'h0F);
            run_op({16'h0, v, 8'h01});
            run_op(32'h0);
            cmp(rd, {24'h0, v & 8'hFB});
            cmp({dmy, wrap, execute_in_place}, {(c == 4'h0 || c == 4'hF) ? 4'hA : c, v[1:0], ~v[3]});
            axi_wr(flash_link_pkg::REG_ADDR, {8'h0, a}, 2'h0);
            axi_wr(flash_link_pkg::REG_DUMMY, {28'h0, c}, 2'h0);
            run_op({14'h0, n, 16'h0002});
            e = 32'h0;
            x = a[7:0];
            for (int k = 0; k <= int'(n); k++) begin
                e = (e << 8) | {24'h0, x};
                x = (x & ~m) | ((x + 8'h01) & m);
            end
            cmp(rd, e);
        end
        axi_wr(8'h20, 32'h0, 2'h2);
        axi_wr(flash_link_pkg::REG_STATUS, 32'h0, 2'h2);
        axi_rd(8'h20, rd, rr);
        cmp({rr, rd}, {2'h2, 32'h0});
        finish_test();
    end
endmodule : serial_flash_volatile_read_config_test
